// ===== common/bkr_pkg.sv
// constants, states and carrier types of the regulator register bank
// assumes one 25 MHz clock; all pins already synchronous to it
`default_nettype none
package bkr_pkg;
   // register offsets (one byte each)
   localparam logic [7:0] BKR_OFS_SP_LOW   = 8'h00;
   localparam logic [7:0] BKR_OFS_SP_HIGH  = 8'h01;
   localparam logic [7:0] BKR_OFS_CTRL     = 8'h02;
   localparam logic [7:0] BKR_OFS_VEND_ID  = 8'h03;
   localparam logic [7:0] BKR_OFS_REV_ID   = 8'h04;
   localparam logic [7:0] BKR_OFS_STATUS   = 8'h05;
   // setpoint fields
   localparam int BKR_SP_EN_BIT   = 7;
   localparam int BKR_SP_MODE_BIT = 6;
   localparam int BKR_SP_CODE_MSB = 5;
   localparam int BKR_SP_CODE_LSB = 0;
   // control fields; bits 3:0 reserved, read zero
   localparam int         BKR_CTL_DIS_BIT  = 7;
   localparam int         BKR_CTL_SLEW_MSB = 6;
   localparam int         BKR_CTL_SLEW_LSB = 4;
   localparam logic [7:0] BKR_CTL_MASK     = 8'hf0;
   // status and revision layout
   localparam int         BKR_STAT_REG_BIT = 7;
   localparam logic [7:0] BKR_ZERO_BYTE    = 8'h00;
   // power-on defaults of the base variant
   localparam logic [7:0] BKR_SP_LOW_RST   = 8'had;
   localparam logic [7:0] BKR_SP_HIGH_RST  = 8'hfc;
   localparam logic [7:0] BKR_CTRL_RST     = 8'hb0;
   // serial port: 7-bit address in bits 7:1, r/w flag in bit 0
   localparam logic [7:0] BKR_I2C_ADDR     = 8'hc0;
   localparam logic [3:0] BKR_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BKR_CNT_ZERO     = 4'h0;
   localparam logic [3:0] BKR_CNT_ONE      = 4'h1;

   typedef enum logic [3:0] {
      BKR_ST_IDLE,
      BKR_ST_ADDR,
      BKR_ST_ADDR_ACK,
      BKR_ST_PTR,
      BKR_ST_PTR_ACK,
      BKR_ST_WDATA,
      BKR_ST_WDATA_ACK,
      BKR_ST_RDATA,
      BKR_ST_RACK,
      BKR_ST_IGNORE
   } bkr_state_t;

   // settings handed to the power stage
   typedef struct packed {
      logic       regulator_on;
      logic       forced_pwm;
      logic [5:0] voltage_code;
      logic       discharge_en;
      logic [2:0] slew_rate;
   } bkr_reg_ctl_t;

   // serial line events of one cycle
   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } bkr_line_ev_t;
endpackage : bkr_pkg
`default_nettype wire

// ===== verilog/bkr_line_events.sv
// start, stop and clock edge detection on the serial lines
// assumes scl and sda already synchronous to the clock
`default_nettype none
module bkr_line_events
   import bkr_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          reset,
   input  wire logic          clk_en,
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   output bkr_pkg::bkr_line_ev_t ev
);
   logic scl_d_r;
   logic sda_d_r;

   // lines idle high
   always_ff @(posedge clock) begin
      if (reset) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else if (clk_en) begin
         scl_d_r <= scl_in;
         sda_d_r <= sda_in;
      end
   end

   always_comb begin
      ev.start    = scl_in && scl_d_r && sda_d_r && !sda_in;
      ev.stop     = scl_in && scl_d_r && !sda_d_r && sda_in;
      ev.scl_rise = scl_in && !scl_d_r;
      ev.scl_fall = !scl_in && scl_d_r;
      ev.sda      = sda_in;
   end
endmodule : bkr_line_events
`default_nettype wire

// ===== verilog/bkr_regbank.sv
// register bank of a step-down regulator behind a serial slave port
// assumes synchronous pins, one clock, an analog stage reading ctl
`default_nettype none
module bkr_regbank
   import bkr_pkg::*;
#(
   parameter logic [7:0] SP_LOW_RST  = BKR_SP_LOW_RST,
   parameter logic [7:0] SP_HIGH_RST = BKR_SP_HIGH_RST,
   parameter logic [7:0] CTRL_RST    = BKR_CTRL_RST,
   parameter logic [7:0] VENDOR_DIE  = 8'h5a, // arbitrary value
   parameter logic [3:0] DIE_REV     = 4'h6,  // arbitrary value
   parameter logic [7:0] SLAVE_ADDR  = BKR_I2C_ADDR
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             clk_en,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe_n,
   input  wire logic             hw_enable_pin,
   input  wire logic             setpoint_select_pin,
   input  wire logic             regulating,
   output bkr_pkg::bkr_reg_ctl_t ctl
);
   import bkr_pkg::*;

   bkr_line_ev_t ev;
   bkr_state_t   state_r;
   bkr_state_t   state_nxt;
   logic [7:0]   sp_low_r;
   logic [7:0]   sp_high_r;
   logic [7:0]   ctrl_r;
   logic [7:0]   ptr_r;
   logic [7:0]   shift_r;
   logic [3:0]   cnt_r;
   logic         read_r;
   logic         master_ack_r;
   logic         sda_oe_n_r;
   logic         sda_out_r;
   bkr_reg_ctl_t ctl_r;
   logic [7:0]   active_sp;
   logic [7:0]   status_byte;
   logic [7:0]   rd_byte;
   logic         byte_done;
   logic         addr_hit;
   logic         wr_commit;

   bkr_line_events u_line (
      .clock  (clock),
      .reset  (reset),
      .clk_en (clk_en),
      .scl_in (scl_in),
      .sda_in (sda_in),
      .ev     (ev)
   );

   assign byte_done = ev.scl_fall && (cnt_r == BKR_BITS_PER_BYTE);
   assign addr_hit  = (shift_r[7:1] == SLAVE_ADDR[7:1]);
   assign wr_commit = (state_r == BKR_ST_WDATA) && byte_done;

   // active setpoint follows the pin every cycle
   assign active_sp = setpoint_select_pin ? sp_high_r
                                          : sp_low_r;

   always_comb begin
      status_byte = BKR_ZERO_BYTE;
      status_byte[BKR_STAT_REG_BIT] = ctl_r.regulator_on && regulating;
   end

   always_comb begin
      unique case (ptr_r)
         BKR_OFS_SP_LOW:  rd_byte = sp_low_r;
         BKR_OFS_SP_HIGH: rd_byte = sp_high_r;
         BKR_OFS_CTRL:    rd_byte = ctrl_r;
         BKR_OFS_VEND_ID: rd_byte = VENDOR_DIE;
         BKR_OFS_REV_ID:  rd_byte = {4'h0, DIE_REV};
         BKR_OFS_STATUS:  rd_byte = status_byte;
         default:         rd_byte = BKR_ZERO_BYTE;
      endcase
   end

   // protocol sequencing
   always_comb begin
      state_nxt = state_r;
      if (ev.stop) begin
         state_nxt = BKR_ST_IDLE;
      end else if (ev.start) begin
         state_nxt = BKR_ST_ADDR;
      end else if (ev.scl_fall) begin
         unique case (state_r)
            BKR_ST_ADDR: begin
               if (byte_done) begin
                  state_nxt = addr_hit ? BKR_ST_ADDR_ACK : BKR_ST_IGNORE;
               end
            end
            BKR_ST_ADDR_ACK: begin
               state_nxt = read_r ? BKR_ST_RDATA : BKR_ST_PTR;
            end
            BKR_ST_PTR: begin
               if (byte_done) begin
                  state_nxt = BKR_ST_PTR_ACK;
               end
            end
            BKR_ST_PTR_ACK:   state_nxt = BKR_ST_WDATA;
            BKR_ST_WDATA: begin
               if (byte_done) begin
                  state_nxt = BKR_ST_WDATA_ACK;
               end
            end
            BKR_ST_WDATA_ACK: state_nxt = BKR_ST_WDATA;
            BKR_ST_RDATA: begin
               if (byte_done) begin
                  state_nxt = BKR_ST_RACK;
               end
            end
            BKR_ST_RACK: begin
               state_nxt = master_ack_r ? BKR_ST_RDATA : BKR_ST_IGNORE;
            end
            BKR_ST_IDLE:      state_nxt = BKR_ST_IDLE;
            BKR_ST_IGNORE:    state_nxt = BKR_ST_IGNORE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_r <= BKR_ST_IDLE;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   // bit counter and shifter
   always_ff @(posedge clock) begin
      if (reset) begin
         cnt_r   <= BKR_CNT_ZERO;
         shift_r <= BKR_ZERO_BYTE;
      end else if (clk_en) begin
         if (ev.start) begin
            cnt_r <= BKR_CNT_ZERO;
         end else if (state_nxt == BKR_ST_RDATA
                      && state_r != BKR_ST_RDATA) begin
            // msb already out: byte ends at the eighth fall
            cnt_r   <= BKR_CNT_ONE;
            shift_r <= rd_byte;
         end else if (state_r == BKR_ST_RDATA) begin
            if (ev.scl_fall) begin
               cnt_r   <= cnt_r + BKR_CNT_ONE;
               shift_r <= {shift_r[6:0], 1'b0};
            end
         end else if (state_r == BKR_ST_ADDR || state_r == BKR_ST_PTR
                      || state_r == BKR_ST_WDATA) begin
            if (ev.scl_rise && cnt_r != BKR_BITS_PER_BYTE) begin
               cnt_r   <= cnt_r + BKR_CNT_ONE;
               shift_r <= {shift_r[6:0], ev.sda};
            end
         end else if (ev.scl_fall) begin
            cnt_r <= BKR_CNT_ZERO;
         end
      end
   end

   // direction flag, master acknowledge, register pointer
   always_ff @(posedge clock) begin
      if (reset) begin
         read_r       <= 1'b0;
         master_ack_r <= 1'b0;
         ptr_r        <= BKR_ZERO_BYTE;
      end else if (clk_en) begin
         if (state_r == BKR_ST_ADDR && byte_done) begin
            read_r <= shift_r[0];
         end
         if (state_r == BKR_ST_RACK && ev.scl_rise) begin
            master_ack_r <= !ev.sda;
         end
         if (state_r == BKR_ST_PTR && byte_done) begin
            ptr_r <= shift_r;
         end else if (wr_commit
                      || (state_r == BKR_ST_RDATA && byte_done)) begin
            ptr_r <= ptr_r + 8'h01;
         end
      end
   end

   // writable registers; identification and status ignore writes
   always_ff @(posedge clock) begin
      if (reset) begin
         sp_low_r  <= SP_LOW_RST;
         sp_high_r <= SP_HIGH_RST;
         ctrl_r    <= CTRL_RST & BKR_CTL_MASK;
      end else if (clk_en && wr_commit) begin
         unique case (ptr_r)
            BKR_OFS_SP_LOW:  sp_low_r  <= shift_r;
            BKR_OFS_SP_HIGH: sp_high_r <= shift_r;
            BKR_OFS_CTRL:    ctrl_r    <= shift_r & BKR_CTL_MASK;
            default: ;
         endcase
      end
   end

   // open-drain data line: drive low for ack and zero read bits
   always_ff @(posedge clock) begin
      if (reset) begin
         sda_oe_n_r <= 1'b1;
         sda_out_r  <= 1'b0;
      end else if (clk_en) begin
         sda_out_r <= 1'b0;
         unique case (state_nxt)
            BKR_ST_ADDR_ACK, BKR_ST_PTR_ACK, BKR_ST_WDATA_ACK:
               sda_oe_n_r <= 1'b0;
            BKR_ST_RDATA: begin
               if (state_r != BKR_ST_RDATA) begin
                  sda_oe_n_r <= rd_byte[7];
               end else if (ev.scl_fall) begin
                  sda_oe_n_r <= shift_r[6];
               end
            end
            default: sda_oe_n_r <= 1'b1;
         endcase
      end
   end

   // settings to the power stage, refreshed every cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         ctl_r <= '0;
      end else if (clk_en) begin
         ctl_r.regulator_on <= hw_enable_pin
                               && active_sp[BKR_SP_EN_BIT];
         ctl_r.forced_pwm   <= active_sp[BKR_SP_MODE_BIT];
         ctl_r.voltage_code <=
            active_sp[BKR_SP_CODE_MSB:BKR_SP_CODE_LSB];
         ctl_r.discharge_en <= ctrl_r[BKR_CTL_DIS_BIT];
         ctl_r.slew_rate    <= ctrl_r[BKR_CTL_SLEW_MSB:BKR_CTL_SLEW_LSB];
      end
   end

   assign ctl      = ctl_r;
   assign sda_oe_n = sda_oe_n_r;
   assign sda_out  = sda_out_r;
endmodule : bkr_regbank
`default_nettype wire

// ===== tb/bkr_chk.sv
// port checker of the regulator register bank
// assumes bkr_pkg compiled first; bound into every bkr_regbank
`default_nettype none
module bkr_chk
   import bkr_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  reset,
   input wire logic                  clk_en,
   input wire logic                  scl_in,
   input wire logic                  sda_in,
   input wire logic                  sda_out,
   input wire logic                  sda_oe_n,
   input wire logic                  hw_enable_pin,
   input wire logic                  setpoint_select_pin,
   input wire logic                  regulating,
   input wire bkr_pkg::bkr_reg_ctl_t ctl
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   a_por_clear: assert property (
      reset && clk_en |=> sda_oe_n && ctl == '0)
      else $error("reset left outputs set");
   a_por_code: assert property (disable iff (reset)
      $past(reset) |=> {ctl.forced_pwm, ctl.voltage_code} ==
      ($past(setpoint_select_pin) ? 7'h7c : 7'h2d))
      else $error("wrong setpoint after reset");
   a_por_enable: assert property (disable iff (reset)
      $past(reset) |=> ctl.regulator_on == $past(hw_enable_pin))
      else $error("wrong enable after reset");
   a_por_control: assert property (disable iff (reset)
      $past(reset) |=> {ctl.discharge_en, ctl.slew_rate} == 4'hb)
      else $error("wrong control after reset");
   a_off_pin_low: assert property (disable iff (reset)
      clk_en && !hw_enable_pin |=> !ctl.regulator_on)
      else $error("regulator on with pin low");
   a_quiet_ctl_hold: assert property (disable iff (reset)
      scl_in && $past(scl_in) && !$past(reset) && $stable(hw_enable_pin)
      && $stable(setpoint_select_pin) |=> $stable(ctl))
      else $error("ctl moved without cause");
   a_oe_after_fall: assert property (disable iff (reset)
      $changed(sda_oe_n) && !$past(reset) |-> !$past(scl_in) &&
      $past(scl_in, 2))
      else $error("data drive changed off the clock fall");
   a_sda_out_low: assert property (disable iff (reset)
      sda_out == 1'b0)
      else $error("data line driven high");
   c_ack: cover property ($fell(sda_oe_n));
   c_sel: cover property ($rose(setpoint_select_pin) && ctl.regulator_on);
   c_off: cover property (!hw_enable_pin && !ctl.regulator_on);
endmodule : bkr_chk
bind bkr_regbank bkr_chk bkr_chk_i (.clock(clock), .reset(reset),
   .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .hw_enable_pin(hw_enable_pin),
   .setpoint_select_pin(setpoint_select_pin), .regulating(regulating),
   .ctl(ctl));
`default_nettype wire

// ===== tb/bkr_host.sv
// host model: drives serial clock and data towards the bank
// assumes the bench resolves open-drain data with a pull-up
`default_nettype none
module bkr_host
   import bkr_pkg::*;
(
   input  wire logic clock,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_drv
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   // six clock periods, data set while low, sampled at end of high
   task automatic bit_x(input logic b, output logic s);
      scl <= 1'b0;
      tick(1);
      sda_drv <= b;
      tick(2);
      scl <= 1'b1;
      tick(3);
      s = sda_line;
   endtask : bit_x
   // start is (1,0), stop is (0,1): data moves while clock high
   task automatic cond(input logic s0, input logic s1);
      logic s;
      // realign to a rising edge before touching the lines
      @(posedge clock);
      bit_x(s0, s);
      sda_drv <= s1;
      tick(3);
   endtask : cond
   task automatic xfer(input logic [7:0] d, input logic m,
                       output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(m, a);
   endtask : xfer
endmodule : bkr_host
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the regulator register bank
// assumes bkr_pkg, bkr_regbank, bkr_chk and bkr_host compiled first
`default_nettype none
module tb_top
   import bkr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] VEND = 8'h4b; // arbitrary value
   localparam logic [3:0] REV  = 4'h9;  // arbitrary value
   logic         clock, reset, clk_en, hw_en, sel, regl;
   logic         scl, sda_drv, sda_out, sda_oe_n, ack;
   wire logic    sda;
   bkr_reg_ctl_t ctl;
   logic [7:0]   rb [8];
   int           n_fail, checked;
   assign sda = sda_drv & sda_oe_n;
   bkr_regbank #(.VENDOR_DIE(VEND), .DIE_REV(REV)) bkr_regbank_i (
      .clock(clock), .reset(reset), .clk_en(clk_en), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .hw_enable_pin(hw_en), .setpoint_select_pin(sel),
      .regulating(regl), .ctl(ctl));
   bkr_host bkr_host_i (.clock(clock), .sda_line(sda), .scl(scl),
      .sda_drv(sda_drv));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : chk
   function automatic logic [15:0] ec(logic e, logic [7:0] s, c);
      return {4'h0, e & s[7], s[6:0], c[7:4]};
   endfunction : ec
   task automatic wr2(input logic [7:0] p, d0, d1);
      logic [7:0] q;
      logic [7:0] b [4];
      b = '{BKR_I2C_ADDR, p, d0, d1};
      bkr_host_i.cond(1'b1, 1'b0);
      foreach (b[i]) begin
         bkr_host_i.xfer(b[i], 1'b1, q, ack);
         chk("write ack", 16'(ack), 16'h0);
      end
      bkr_host_i.cond(1'b0, 1'b1);
   endtask : wr2
   task automatic rd(input logic [7:0] p, input int n);
      bkr_host_i.cond(1'b1, 1'b0);
      bkr_host_i.xfer(BKR_I2C_ADDR, 1'b1, rb[0], ack);
      bkr_host_i.xfer(p, 1'b1, rb[0], ack);
      bkr_host_i.cond(1'b1, 1'b0);
      bkr_host_i.xfer(BKR_I2C_ADDR | 8'h01, 1'b1, rb[0], ack);
      for (int i = 0; i < n; i++) begin
         bkr_host_i.xfer(8'hff, 1'(i == n - 1), rb[i], ack);
      end
      bkr_host_i.cond(1'b0, 1'b1);
      @(negedge clock);
   endtask : rd
   task automatic t_por();
      logic [7:0] e [7];
      e = '{8'had, 8'hfc, 8'hb0, VEND, {4'h0, REV}, 8'h80, 8'h00};
      rd(8'h00, 7);
      foreach (e[i]) chk("reg", 16'(rb[i]), 16'(e[i]));
      chk("ctl", 16'(ctl), ec(1'b1, 8'had, 8'hb0));
      $display("test por done");
   endtask : t_por
   task automatic t_write();
      wr2(8'h00, 8'hc5, 8'h2a);
      @(negedge clock);
      chk("ctl low", 16'(ctl), ec(1'b1, 8'hc5, 8'hb0));
      @(posedge clock);
      sel <= 1'b1;
      repeat (2) @(negedge clock);
      chk("ctl high", 16'(ctl), ec(1'b1, 8'h2a, 8'hb0));
      @(posedge clock);
      sel <= 1'b0;
      hw_en <= 1'b0;
      repeat (2) @(negedge clock);
      chk("ctl off", 16'(ctl), ec(1'b0, 8'hc5, 8'hb0));
      rd(8'h05, 1);
      chk("status off", 16'(rb[0]), 16'h0);
      @(posedge clock);
      hw_en <= 1'b1;
      $display("test write done");
   endtask : t_write
   task automatic t_ro();
      wr2(8'h02, 8'h5f, 8'hff);
      rd(8'h02, 2);
      chk("control", 16'(rb[0]), 16'h50);
      chk("vendor", 16'(rb[1]), 16'(VEND));
      chk("ctl ctrl", 16'(ctl), ec(1'b1, 8'hc5, 8'h50));
      bkr_host_i.cond(1'b1, 1'b0);
      bkr_host_i.xfer(8'ha0, 1'b1, rb[0], ack);
      chk("foreign ack", 16'(ack), 16'h1);
      bkr_host_i.cond(1'b0, 1'b1);
      regl <= 1'b0;
      rd(8'h05, 1);
      chk("status idle", 16'(rb[0]), 16'h0);
      @(posedge clock);
      regl <= 1'b1;
      $display("test ro done");
   endtask : t_ro
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_of_test();
   end
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      hw_en = 1'b1;
      sel = 1'b0;
      regl = 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      t_por();
      t_write();
      t_ro();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
